// *** rtl/tmrcw_consts.svh ***
`ifndef TMRCW_CONSTS_SVH
`define TMRCW_CONSTS_SVH
// Register word addresses on the APB
`define TMRCW_ADDR_CTRL 12'h000
`define TMRCW_ADDR_CNT 12'h004
`define TMRCW_ADDR_CMP 12'h008
`define TMRCW_ADDR_FLAGS 12'h00C
`define TMRCW_ADDR_MASK 12'h010
`define TMRCW_ADDR_PORT 12'h014
`define TMRCW_ADDR_ACTIVE 12'h018
// Control register fields
`define TMRCW_CTRL_CS_LSB 0
`define TMRCW_CTRL_WGM_LSB 3
`define TMRCW_CTRL_COM_LSB 5
`define TMRCW_CTRL_FOC_BIT 7
// Flag and mask fields
`define TMRCW_FLAG_OVF_BIT 0
`define TMRCW_FLAG_CMP_BIT 1
// Port register fields
`define TMRCW_PORT_VAL_BIT 0
`define TMRCW_PORT_DIR_BIT 1
`define TMRCW_PORT_GIE_BIT 2
`define TMRCW_PORT_ACK_BIT 3
// Counter extremes, zero tick select and output action codes
`define TMRCW_BOTTOM 8'h00
`define TMRCW_MAX 8'hFF
`define TMRCW_ZERO3 3'h0
`define TMRCW_COM_NONE 2'h0
`define TMRCW_COM_TOGGLE 2'h1
`define TMRCW_COM_CLEAR 2'h2
`define TMRCW_COM_SET 2'h3
`endif

// *** rtl/tmrcw_pkg.sv ***
package tmrcw_pkg;
    // Waveform generation modes
    typedef enum logic [1:0] {
        TMRCW_MODE_NORMAL = 2'h0,
        TMRCW_MODE_PCPWM = 2'h1,
        TMRCW_MODE_CTC = 2'h2,
        TMRCW_MODE_FPWM = 2'h3
    } tmrcw_mode_t;
endpackage : tmrcw_pkg

// *** rtl/tmrcw_tick_sync.sv ***
`timescale 1ns/1ps
// Three-stage synchroniser for an asynchronous tick source
module tmrcw_tick_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic level_out,
    output logic rise_out
);
    // State: three sync stages and accepted level
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } tmrcw_sync_t;
    tmrcw_sync_t st_q;
    tmrcw_sync_t st_d;

    // Next state; a change counts once stages two and three agree
    always_comb begin
        st_d = st_q;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3) begin
            st_d.lvl = st_q.s3;
        end
    end

    // Register the state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_out = st_q.lvl;
    assign rise_out = (st_q.s2 == st_q.s3) && st_q.s3 && !st_q.lvl;
endmodule : tmrcw_tick_sync

// *** rtl/tmrcw_timer.sv ***
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`include "tmrcw_consts.svh"
module tmrcw_timer #(
    parameter int PRESCALE_W = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_tick_in,
    output logic compare_output_pin_o,
    output logic compare_output_pin_oe,
    output logic compare_irq,
    output logic overflow_irq
);
    // Whole state of the timer
    typedef struct packed {
        logic [2:0] tick_source_select;
        tmrcw_pkg::tmrcw_mode_t waveform_mode_bits;
        logic [1:0] output_action_bits;
        logic [7:0] counter_value;
        logic [7:0] compare_value;
        logic [7:0] compare_buffer;
        logic count_down;
        logic compare_match_flag;
        logic overflow_flag;
        logic compare_irq_enable;
        logic overflow_irq_enable;
        logic port_value;
        logic output_pin_direction;
        logic global_irq_on;
        logic compare_output;
        logic block_match;
        logic match_pending;
        logic [PRESCALE_W-1:0] prescale;
        logic [31:0] rdata;
    } tmrcw_state_t;
    tmrcw_state_t st_q;
    tmrcw_state_t st_d;

    logic ext_level;
    logic ext_rise;
    logic timer_tick;
    logic wr_en;
    logic rd_en;
    logic is_pwm;
    logic at_max;
    logic at_bottom;
    logic cmp_equal;
    logic fall_seen;
    logic ext_level_q;

    // External tick pin crosses into pclk domain
    tmrcw_tick_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(ext_tick_in),
        .level_out(ext_level),
        .rise_out(ext_rise)
    );

    // Bus strobes: always ready; read data is registered in the setup cycle,
    // so it already stands when the access cycle shows pready
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = st_q.rdata;

    assign is_pwm = (st_q.waveform_mode_bits == tmrcw_pkg::TMRCW_MODE_PCPWM) ||
                    (st_q.waveform_mode_bits == tmrcw_pkg::TMRCW_MODE_FPWM);
    assign at_max = (st_q.counter_value == `TMRCW_MAX);
    assign at_bottom = (st_q.counter_value == `TMRCW_BOTTOM);
    assign cmp_equal = (st_q.counter_value == st_q.compare_value);

    // Tick selection; 1 is every pclk, 2..5 are prescaler taps, 6/7 external edges
    always_comb begin
        timer_tick = 1'b0;
        unique case (st_q.tick_source_select)
            3'h0: timer_tick = 1'b0;
            3'h1: timer_tick = 1'b1;
            3'h2: timer_tick = (st_q.prescale[2:0] == 3'h7);
            3'h3: timer_tick = (st_q.prescale[5:0] == 6'h3F);
            3'h4: timer_tick = (st_q.prescale[7:0] == 8'hFF);
            3'h5: timer_tick = (st_q.prescale[PRESCALE_W-1:0] == '1);
            // Falling edge of the accepted level
            3'h6: timer_tick = fall_seen;
            3'h7: timer_tick = ext_rise;
        endcase
    end

    // Falling edge of the accepted external level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_level_q <= 1'b0;
        end else begin
            ext_level_q <= ext_level;
        end
    end
    assign fall_seen = ext_level_q && !ext_level;

    // Next-state logic for counter, compare and output
    always_comb begin
        logic do_match;
        logic forced;
        logic [1:0] act;
        logic ovf_set;
        do_match = 1'b0;
        ovf_set = 1'b0;
        forced = 1'b0;
        act = `TMRCW_COM_NONE;
        st_d = st_q;
        st_d.prescale = st_q.prescale + 1'b1;
        // global enable and ack come from core side port register
        // no tick when select is zero; counter holds
        if (timer_tick) begin
            // a blocked tick consumes the block
            st_d.block_match = 1'b0;
            // flag set on the tick after equality
            if (st_q.match_pending) begin
                do_match = 1'b1;
            end
            // counting is steered by the mode bits, with count_down in PCPWM and compare equality in CTC
            unique case (st_q.waveform_mode_bits)
                tmrcw_pkg::TMRCW_MODE_NORMAL, tmrcw_pkg::TMRCW_MODE_FPWM: begin
                    // free running up count with wrap
                    st_d.counter_value = st_q.counter_value + 8'h01;
                    if (at_max) begin
                        ovf_set = 1'b1;
                    end
                    // Single slope: no stale direction may steer the PWM output
                    st_d.count_down = 1'b0;
                end
                tmrcw_pkg::TMRCW_MODE_CTC: begin
                    if (cmp_equal) begin
                        st_d.counter_value = `TMRCW_BOTTOM;
                    end else begin
                        st_d.counter_value = st_q.counter_value + 8'h01;
                    end
                    if (at_max) begin
                        ovf_set = 1'b1;
                    end
                end
                tmrcw_pkg::TMRCW_MODE_PCPWM: begin
                    // Dual slope: turn at max and bottom
                    if (st_q.count_down) begin
                        st_d.counter_value = st_q.counter_value - 8'h01;
                        if (st_q.counter_value == 8'h01) begin
                            st_d.count_down = 1'b0;
                            ovf_set = 1'b1;
                        end
                    end else begin
                        st_d.counter_value = st_q.counter_value + 8'h01;
                        if (st_q.counter_value == 8'hFE) begin
                            st_d.count_down = 1'b1;
                        end
                    end
                end
            endcase
            // update active copy when leaving max in both PWM modes
            if ((st_q.waveform_mode_bits == tmrcw_pkg::TMRCW_MODE_FPWM && at_max) ||
                (st_q.waveform_mode_bits == tmrcw_pkg::TMRCW_MODE_PCPWM && at_max)) begin
                st_d.compare_value = st_q.compare_buffer;
            end
        end
        // compare flag clears on interrupt acknowledge or write of one; overflow flag on write of one only
        if (wr_en && paddr == `TMRCW_ADDR_FLAGS) begin
            if (pwdata[`TMRCW_FLAG_CMP_BIT]) begin
                st_d.compare_match_flag = 1'b0;
            end
            if (pwdata[`TMRCW_FLAG_OVF_BIT]) begin
                st_d.overflow_flag = 1'b0;
            end
        end
        if (wr_en && paddr == `TMRCW_ADDR_PORT && pwdata[`TMRCW_PORT_ACK_BIT]) begin
            st_d.compare_match_flag = 1'b0;
        end
        // hardware set wins over any clear
        if (do_match) begin
            st_d.compare_match_flag = 1'b1;
        end
        if (ovf_set) begin
            st_d.overflow_flag = 1'b1;
        end
        if (wr_en && paddr == `TMRCW_ADDR_CTRL && pwdata[`TMRCW_CTRL_FOC_BIT] && !is_pwm) begin
            forced = 1'b1;
        end
        // a match uses the stored bits; a force uses the bits written with it
        act = forced ? pwdata[`TMRCW_CTRL_COM_LSB +: 2] : st_q.output_action_bits;
        if ((do_match || forced) && act != `TMRCW_COM_NONE) begin
            if (!is_pwm) begin
                unique case (act)
                    `TMRCW_COM_TOGGLE: st_d.compare_output = !st_q.compare_output;
                    `TMRCW_COM_CLEAR: st_d.compare_output = 1'b0;
                    `TMRCW_COM_SET: st_d.compare_output = 1'b1;
                    default: st_d.compare_output = st_q.compare_output;
                endcase
            end else if (act[1]) begin
                // PWM: set on up match when non-inverted
                st_d.compare_output = act[0] ^ !st_q.count_down;
            end
        end
        // Fast PWM sets (non-inverted) at bottom
        if (timer_tick && is_pwm && act[1] && at_max &&
            st_q.waveform_mode_bits == tmrcw_pkg::TMRCW_MODE_FPWM) begin
            st_d.compare_output = !act[0];
        end
        // Register writes
        if (wr_en) begin
            unique case (paddr)
                `TMRCW_ADDR_CTRL: begin
                    // mode change leaves the output state alone
                    st_d.tick_source_select = pwdata[`TMRCW_CTRL_CS_LSB +: 3];
                    st_d.waveform_mode_bits = tmrcw_pkg::tmrcw_mode_t'(
                        pwdata[`TMRCW_CTRL_WGM_LSB +: 2]);
                    st_d.output_action_bits = pwdata[`TMRCW_CTRL_COM_LSB +: 2];
                end
                `TMRCW_ADDR_CNT: begin
                    // write beats count; block next match
                    st_d.counter_value = pwdata[7:0];
                    st_d.block_match = 1'b1;
                    st_d.match_pending = 1'b0;
                end
                `TMRCW_ADDR_CMP: begin
                    st_d.compare_buffer = pwdata[7:0];
                    if (!is_pwm) begin
                        st_d.compare_value = pwdata[7:0];
                    end
                end
                `TMRCW_ADDR_MASK: begin
                    st_d.overflow_irq_enable = pwdata[`TMRCW_FLAG_OVF_BIT];
                    st_d.compare_irq_enable = pwdata[`TMRCW_FLAG_CMP_BIT];
                end
                `TMRCW_ADDR_PORT: begin
                    st_d.port_value = pwdata[`TMRCW_PORT_VAL_BIT];
                    st_d.output_pin_direction = pwdata[`TMRCW_PORT_DIR_BIT];
                    st_d.global_irq_on = pwdata[`TMRCW_PORT_GIE_BIT];
                end
                default: begin
                end
            endcase
        end
        // equality is acted on at the next tick unless a counter write blocked it
        // it is consumed by that tick so one match never fires twice
        st_d.match_pending = (st_d.counter_value == st_d.compare_value) &&
                             !st_d.block_match;
        // Read data register; unmapped reads as zero
        st_d.rdata = 32'h0000_0000;
        if (rd_en) begin
            unique case (paddr)
                `TMRCW_ADDR_CTRL: st_d.rdata = {24'h0, 1'b0, st_q.output_action_bits,
                                            st_q.waveform_mode_bits,
                                            st_q.tick_source_select};
                `TMRCW_ADDR_CNT: st_d.rdata = {24'h0, st_q.counter_value};
                `TMRCW_ADDR_CMP: st_d.rdata = {24'h0, is_pwm ? st_q.compare_buffer :
                                                      st_q.compare_value};
                `TMRCW_ADDR_FLAGS: st_d.rdata = {30'h0, st_q.compare_match_flag,
                                             st_q.overflow_flag};
                `TMRCW_ADDR_MASK: st_d.rdata = {30'h0, st_q.compare_irq_enable,
                                            st_q.overflow_irq_enable};
                `TMRCW_ADDR_PORT: st_d.rdata = {29'h0, st_q.global_irq_on,
                                            st_q.output_pin_direction, st_q.port_value};
                `TMRCW_ADDR_ACTIVE: st_d.rdata = {21'h0, at_bottom, at_max,
                                              st_q.compare_output, st_q.compare_value};
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // Register the state; output state resets to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // pin override when any action bit set; direction from port bit
    assign compare_output_pin_o = (st_q.output_action_bits != `TMRCW_COM_NONE) ?
                                  st_q.compare_output : st_q.port_value;
    assign compare_output_pin_oe = st_q.output_pin_direction;
    // interrupt request gated by enable and global flag
    assign compare_irq = st_q.compare_match_flag && st_q.compare_irq_enable &&
                         st_q.global_irq_on;
    assign overflow_irq = st_q.overflow_flag && st_q.overflow_irq_enable &&
                          st_q.global_irq_on;

    // Assertion helpers
    logic [7:0] cnt_prev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_prev <= 8'h00;
        end else begin
            cnt_prev <= st_q.counter_value;
        end
    end

    sequence cnt_write_s;
        wr_en && paddr == `TMRCW_ADDR_CNT;
    endsequence

    AST_STOPPED_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q.tick_source_select == `TMRCW_ZERO3 && !wr_en) |=>
        $stable(st_q.counter_value))
        else $error("counter moved while stopped");
    AST_WRITE_WINS: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_write_s |=> st_q.counter_value == $past(pwdata[7:0]))
        else $error("counter write lost");
    AST_NORMAL_INC: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_tick && !wr_en && st_q.waveform_mode_bits == tmrcw_pkg::TMRCW_MODE_NORMAL)
        |=> st_q.counter_value == cnt_prev + 8'h01)
        else $error("normal mode did not increment");
    AST_OVF_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_tick && at_max && st_q.waveform_mode_bits == tmrcw_pkg::TMRCW_MODE_NORMAL)
        |=> st_q.overflow_flag)
        else $error("overflow flag not set");
    AST_CTC_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_tick && cmp_equal && !wr_en &&
         st_q.waveform_mode_bits == tmrcw_pkg::TMRCW_MODE_CTC)
        |=> st_q.counter_value == `TMRCW_BOTTOM)
        else $error("ctc did not clear");
    AST_FLAG_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_tick && st_q.match_pending) |=> st_q.compare_match_flag)
        else $error("compare flag not set");
    AST_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_write_s |=> !st_q.match_pending)
        else $error("match not blocked by counter write");
    AST_PIN_OVERRIDE: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q.output_action_bits != `TMRCW_COM_NONE) |->
        compare_output_pin_o == st_q.compare_output)
        else $error("pin override wrong");
    AST_ACTION_NONE: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q.output_action_bits == `TMRCW_COM_NONE && !wr_en) |=>
        $stable(st_q.compare_output))
        else $error("output changed with no action");
endmodule : tmrcw_timer

// *** testbench/test_timer8_compare_waveform.sv ***
`timescale 1ns/1ps
`include "tmrcw_consts.svh"
module test_timer8_compare_waveform;
    logic pclk; // 250 MHz bus clock
    logic presetn; // Active-low reset
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ext_tick_in; // Driven by hand so every tick is counted exactly
    logic pin_o;
    logic pin_oe;
    logic compare_irq;
    logic overflow_irq;
    logic [31:0] rd; // Last read data
    int n_mismatch;
    int n_checks;
    logic [1:0] fc [4] = '{`TMRCW_COM_CLEAR, `TMRCW_COM_SET, `TMRCW_COM_TOGGLE, `TMRCW_COM_NONE};
    logic fe [4] = '{1'b0, 1'b1, 1'b0, 1'b0}; // Output state after each forced match
    logic [1:0] pm [2] = '{tmrcw_pkg::TMRCW_MODE_PCPWM, tmrcw_pkg::TMRCW_MODE_FPWM};

    tmrcw_timer #(.PRESCALE_W(10)) uut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .ext_tick_in(ext_tick_in),
        .compare_output_pin_o(pin_o),
        .compare_output_pin_oe(pin_oe),
        .compare_irq(compare_irq),
        .overflow_irq(overflow_irq)
    );

    // Free-running clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Prints counts and verdict, then stops the run
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; read data is taken at the edge that sees pready high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int w;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        w = 0;
        // Hold the request until pready is seen high at an edge
        do begin
            @(posedge pclk);
            w++;
        end while (pready !== 1'b1 && w < 50);
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH at %0t: no pready", $time);
            finish_test();
        end
        if (!wr) begin
            rd = prdata;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    // Masked read compare, so single fields can be checked
    task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd & m, exp);
    endtask : rchk

    // One rising edge on the tick pin; long enough for the synchroniser
    task automatic tick_pulse();
        @(posedge pclk);
        ext_tick_in <= 1'b1;
        repeat (8) @(posedge pclk);
        ext_tick_in <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : tick_pulse

    function automatic logic [31:0] ctl(input logic [2:0] cs, input logic [1:0] md,
                                        input logic [1:0] com, input logic foc);
        return {24'h0, foc, com, md, cs};
    endfunction : ctl

    // Watchdog: the sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        finish_test();
    end

    initial begin
        n_mismatch = 0;
        n_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext_tick_in = 1'b0;
        repeat (20) @(posedge pclk);
        chk({pin_o, pin_oe}, 32'h0);
        presetn <= 1'b1;
        rchk(`TMRCW_ADDR_ACTIVE, 32'h100, 32'h0);
        rchk(12'h0FC, 32'hFFFFFFFF, 32'h0);
        // Stopped timer holds a written value
        wr(`TMRCW_ADDR_CNT, 32'h10);
        wr(`TMRCW_ADDR_CTRL, ctl(3'h0, tmrcw_pkg::TMRCW_MODE_NORMAL, 2'h0, 1'b0));
        tick_pulse();
        rchk(`TMRCW_ADDR_CNT, 32'hFF, 32'h10);
        // Normal mode: wrap, extremes, overflow flag
        wr(`TMRCW_ADDR_CMP, 32'h40);
        wr(`TMRCW_ADDR_CNT, 32'hFE);
        wr(`TMRCW_ADDR_FLAGS, 32'h3);
        wr(`TMRCW_ADDR_CTRL, ctl(3'h7, tmrcw_pkg::TMRCW_MODE_NORMAL, 2'h0, 1'b0));
        tick_pulse();
        rchk(`TMRCW_ADDR_CNT, 32'hFF, 32'hFF);
        rchk(`TMRCW_ADDR_ACTIVE, 32'h600, 32'h200);
        rchk(`TMRCW_ADDR_FLAGS, 32'h1, 32'h0);
        tick_pulse();
        rchk(`TMRCW_ADDR_CNT, 32'hFF, 32'h0);
        rchk(`TMRCW_ADDR_ACTIVE, 32'h600, 32'h400);
        rchk(`TMRCW_ADDR_FLAGS, 32'h1, 32'h1);
        wr(`TMRCW_ADDR_MASK, 32'h1);
        wr(`TMRCW_ADDR_PORT, 32'h4);
        repeat (2) @(posedge pclk);
        chk(overflow_irq, 32'h1);
        // A counter write equal to compare loses that match
        wr(`TMRCW_ADDR_FLAGS, 32'h3);
        wr(`TMRCW_ADDR_CNT, 32'h40);
        tick_pulse();
        rchk(`TMRCW_ADDR_FLAGS, 32'h2, 32'h0);
        // Flag is set one tick after equality
        wr(`TMRCW_ADDR_CNT, 32'h3E);
        tick_pulse();
        tick_pulse();
        rchk(`TMRCW_ADDR_FLAGS, 32'h2, 32'h0);
        tick_pulse();
        rchk(`TMRCW_ADDR_FLAGS, 32'h2, 32'h2);
        // Interrupt request, then software write-one clear
        wr(`TMRCW_ADDR_MASK, 32'h2);
        wr(`TMRCW_ADDR_PORT, 32'h4);
        repeat (2) @(posedge pclk);
        chk(compare_irq, 32'h1);
        wr(`TMRCW_ADDR_FLAGS, 32'h2);
        repeat (2) @(posedge pclk);
        chk(compare_irq, 32'h0);
        // Interrupt taken clears the flag
        wr(`TMRCW_ADDR_CNT, 32'h3F);
        tick_pulse();
        tick_pulse();
        wr(`TMRCW_ADDR_PORT, 32'hC);
        rchk(`TMRCW_ADDR_FLAGS, 32'h2, 32'h0);
        // Clear-on-match mode with toggle output
        wr(`TMRCW_ADDR_CMP, 32'h05);
        wr(`TMRCW_ADDR_CNT, 32'h04);
        wr(`TMRCW_ADDR_PORT, 32'h2);
        wr(`TMRCW_ADDR_CTRL, ctl(3'h7, tmrcw_pkg::TMRCW_MODE_CTC, `TMRCW_COM_TOGGLE, 1'b0));
        tick_pulse();
        tick_pulse();
        rchk(`TMRCW_ADDR_CNT, 32'hFF, 32'h0);
        rchk(`TMRCW_ADDR_ACTIVE, 32'h100, 32'h100);
        chk({pin_o, pin_oe}, 32'h3);
        // Action bits zero: no change at match, port value on the pin
        wr(`TMRCW_ADDR_CTRL, ctl(3'h7, tmrcw_pkg::TMRCW_MODE_NORMAL, `TMRCW_COM_NONE, 1'b0));
        wr(`TMRCW_ADDR_CNT, 32'h04);
        tick_pulse();
        tick_pulse();
        rchk(`TMRCW_ADDR_ACTIVE, 32'h100, 32'h100);
        chk({pin_o, pin_oe}, 32'h1);
        // Force strobe with every action code
        wr(`TMRCW_ADDR_FLAGS, 32'h3);
        wr(`TMRCW_ADDR_CNT, 32'h22);
        for (int i = 0; i < 4; i++) begin
            wr(`TMRCW_ADDR_CTRL, ctl(3'h0, tmrcw_pkg::TMRCW_MODE_NORMAL, fc[i], 1'b1));
            rchk(`TMRCW_ADDR_ACTIVE, 32'h100, {23'h0, fe[i], 8'h0});
        end
        rchk(`TMRCW_ADDR_FLAGS, 32'h2, 32'h0);
        rchk(`TMRCW_ADDR_CNT, 32'hFF, 32'h22);
        // Double buffering in both PWM modes only
        for (int i = 0; i < 2; i++) begin
            wr(`TMRCW_ADDR_CTRL, ctl(3'h0, tmrcw_pkg::TMRCW_MODE_NORMAL, 2'h0, 1'b0));
            wr(`TMRCW_ADDR_CMP, 32'h30);
            rchk(`TMRCW_ADDR_ACTIVE, 32'hFF, 32'h30);
            wr(`TMRCW_ADDR_CNT, 32'hFE);
            wr(`TMRCW_ADDR_CTRL, ctl(3'h7, pm[i], 2'h0, 1'b0));
            wr(`TMRCW_ADDR_CMP, 32'h80);
            rchk(`TMRCW_ADDR_CMP, 32'hFF, 32'h80);
            rchk(`TMRCW_ADDR_ACTIVE, 32'hFF, 32'h30);
            tick_pulse();
            tick_pulse();
            rchk(`TMRCW_ADDR_ACTIVE, 32'hFF, 32'h80);
        end
        finish_test();
    end
endmodule : test_timer8_compare_waveform
